// [tsd_top.sv]
// Transmit serializer with programmable output delay tap counter
//
// What this block does
// R1: Load takes nine-bit tap value input
// R2: Tap value settles a cycle before load
// R3: Each update moves one to eight taps
// R4: Compensation covers only the programmed delay
// R5: Current tap count shown on output bus
// R6: Compensation enabled: controller updates tap output
// R7: Serial data out on the fast clock
// R8: Tristate out: direct pass or serialized byte
// R9: Forty-bit control buses wired to controller
// R10: Parallel width four or eight, default eight
// R11: Byte tristate source is default, paired slice
// R12: Direct source: fabric drives tristate input
// R13: Serial output initial value, default one
// R14: Load pulse copies tap value, enable low
// R15: Enable high steps one tap per cycle
// R16: Taps wrap between 511 and 0
// R17: Initial value holds until first word
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tsd_defines.svh"

module tsd_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] par_data,
  input wire logic par_valid,
  output logic par_ready,
  input wire logic [8:0] tap_value_in,
  input wire logic tap_load,
  input wire logic tap_ce,
  input wire logic tap_inc,
  input wire logic vt_comp_enable,
  output logic [8:0] tap_value_out,
  input wire logic direct_tristate_in,
  input wire logic byte_tristate_in,
  output logic ser_out,
  output logic t_out,
  input wire logic [39:0] rx_ctrl_in,
  output logic [39:0] rx_ctrl_out,
  input wire logic [39:0] tx_ctrl_in,
  output logic [39:0] tx_ctrl_out
);

  tsd_pkg::tsd_ctrl_t ctrl_q;
  tsd_pkg::tsd_ctrl_in_t cin;
  tsd_pkg::tsd_ctrl_out_t cout_d;
  tsd_pkg::tsd_status_t stat_d;
  tsd_pkg::tsd_status_t wclr;
  logic [8:0] prog_q;
  logic [8:0] comp_tap;
  logic [8:0] tap_in_prev_q;
  logic [8:0] jump;
  logic prog_wr;
  logic stat_wr;
  logic load_ok;
  logic early_ev;
  logic jump_ev;
  logic early_q;
  logic jump_q;
  logic div_mism;
  logic ser_running;
  logic t_ser_q;
  logic [31:0] rdata_d;

  // ==========================================================
  // Register decode
  assign prog_wr = reg_wr && reg_addr == `TSD_ADDR_PROG;
  assign stat_wr = reg_wr && reg_addr == `TSD_ADDR_STAT;
  assign wclr = tsd_pkg::tsd_status_t'(reg_wdata);
  assign cin = tsd_pkg::tsd_ctrl_in_t'(tx_ctrl_in); // [R9]

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= tsd_pkg::tsd_ctrl_t'(`TSD_CTRL_RST); // [R10] [R11] [R13]
    end else if (reg_wr && reg_addr == `TSD_ADDR_CTRL) begin
      ctrl_q <= tsd_pkg::tsd_ctrl_t'(reg_wdata[`TSD_CTRL_W-1:0]);
    end
  end

  // Programmed delay, the base that compensation tracks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_q <= `TSD_TAP_RST;
    end else if (prog_wr) begin
      prog_q <= reg_wdata[8:0]; // [R4]
    end
  end

  // ==========================================================
  // Delay line
  assign comp_tap = prog_q + cin.comp_delta; // [R4]

  tsd_delay_line u_dly (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .mode(ctrl_q.mode),
    .load(tap_load),
    .ce(tap_ce),
    .inc(tap_inc),
    .tap_in(tap_value_in),
    .vtc_en(vt_comp_enable),
    .comp_valid(cin.comp_valid),
    .comp_tap(comp_tap),
    .prog_wr(prog_wr),
    .prog_tap(reg_wdata[8:0]),
    .tap_q(tap_value_out) // [R5]
  );

  // ==========================================================
  // Checks on the fabric's load discipline
  assign load_ok = ctrl_q.mode == tsd_pkg::TSD_DLY_VAR_LOAD && tap_load &&
    !tap_ce && !vt_comp_enable && !prog_wr;
  assign early_ev = load_ok && tap_value_in != tap_in_prev_q; // [R2]
  assign jump = tap_value_in - tap_value_out;
  assign jump_ev = load_ok && (jump == 9'h000 ||
    (jump > `TSD_MAX_JUMP && jump < `TSD_MIN_BACK)); // [R3]

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tap_in_prev_q <= `TSD_TAP_RST;
    end else begin
      tap_in_prev_q <= tap_value_in;
    end
  end

  // Sticky flags, set wins over a write-one clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      early_q <= 1'b0;
    end else if (early_ev) begin
      early_q <= 1'b1; // [R2]
    end else if (stat_wr && wclr.early_err) begin
      early_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      jump_q <= 1'b0;
    end else if (jump_ev) begin
      jump_q <= 1'b1; // [R3]
    end else if (stat_wr && wclr.jump_err) begin
      jump_q <= 1'b0;
    end
  end

  // Width must be twice the controller divide setting
  assign div_mism = cin.div_mode !=
    (ctrl_q.wide8 ? `TSD_DIV8 : `TSD_DIV4); // [R10]

  // ==========================================================
  // Serializer
  tsd_serializer u_ser (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wide8(ctrl_q.wide8),
    .init_val(ctrl_q.init_val),
    .par_data(par_data),
    .par_valid(par_valid),
    .par_ready(par_ready),
    .ser_out(ser_out),
    .running(ser_running)
  );

  // ==========================================================
  // Tristate path
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      t_ser_q <= `TSD_INIT_RST;
    end else begin
      t_ser_q <= byte_tristate_in; // [R8] [R11]
    end
  end

  // Direct source passes straight through without a flop
  assign t_out = ctrl_q.tsel_byte ? t_ser_q : direct_tristate_in; // [R8]

  // ==========================================================
  // Controller buses
  always_comb begin
    cout_d = '0;
    cout_d.vtc_en = vt_comp_enable;
    cout_d.tap = tap_value_out;
    cout_d.t_bit = t_ser_q;
    cout_d.ser_bit = ser_out;
    cout_d.wide8 = ctrl_q.wide8;
    cout_d.running = ser_running;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ctrl_out <= 40'h00_0000_0000;
      rx_ctrl_out <= 40'h00_0000_0000;
    end else begin
      tx_ctrl_out <= cout_d; // [R9]
      // Programmed delay echoed so input delays can match
      rx_ctrl_out <= {rx_ctrl_in[39:9], prog_q}; // [R9] [R4]
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  always_comb begin
    stat_d = '0;
    stat_d.running = ser_running;
    stat_d.jump_err = jump_q;
    stat_d.early_err = early_q;
    stat_d.div_mism = div_mism;
    stat_d.tap = tap_value_out;
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `TSD_ADDR_CTRL: rdata_d = 32'(ctrl_q);
        `TSD_ADDR_PROG: rdata_d = 32'(prog_q);
        `TSD_ADDR_STAT: rdata_d = stat_d;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic [7:0] cap_q;
  logic take;
  logic fab_free;
  assign take = par_valid && par_ready;
  assign fab_free = !vt_comp_enable && !prog_wr;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_q <= 8'h00;
    end else if (take) begin
      cap_q <= par_data;
    end
  end

  sequence s_byte_out;
    ser_out == cap_q[0] ##1 ser_out == cap_q[1] ##1
    ser_out == cap_q[2] ##1 ser_out == cap_q[3] ##1
    ser_out == cap_q[4] ##1 ser_out == cap_q[5] ##1
    ser_out == cap_q[6] ##1 ser_out == cap_q[7];
  endsequence

  sequence s_nib_out;
    ser_out == cap_q[0] ##1 ser_out == cap_q[1] ##1
    ser_out == cap_q[2] ##1 ser_out == cap_q[3];
  endsequence

  sequence s_step_up;
    ctrl_q.mode != tsd_pkg::TSD_DLY_FIXED && tap_ce && tap_inc &&
      fab_free;
  endsequence

  sequence s_step_dn;
    ctrl_q.mode != tsd_pkg::TSD_DLY_FIXED && tap_ce && !tap_inc &&
      fab_free;
  endsequence

  load_takes_tap_a: assert property ( // [R1] [R14]
    load_ok |=> tap_value_out == $past(tap_value_in))
    else $error("tap load not applied");

  step_up_a: assert property ( // [R15]
    s_step_up |=> tap_value_out == 9'($past(tap_value_out) + 9'h001))
    else $error("tap step up wrong");

  step_down_a: assert property ( // [R15]
    s_step_dn |=> tap_value_out == 9'($past(tap_value_out) - 9'h001))
    else $error("tap step down wrong");

  wrap_top_a: assert property ( // [R16]
    s_step_up and tap_value_out == 9'h1ff |=> tap_value_out == 9'h000)
    else $error("tap did not wrap to zero");

  wrap_bottom_a: assert property ( // [R16]
    s_step_dn and tap_value_out == 9'h000 |=> tap_value_out == 9'h1ff)
    else $error("tap did not wrap to top");

  vtc_follow_a: assert property ( // [R6]
    vt_comp_enable && cin.comp_valid && !prog_wr
    |=> tap_value_out == $past(comp_tap))
    else $error("compensated tap not shown");

  vtc_hold_a: assert property ( // [R4]
    vt_comp_enable && !cin.comp_valid && !prog_wr |=> $stable(tap_value_out))
    else $error("fabric moved a compensated tap");

  fixed_hold_a: assert property ( // [R15]
    ctrl_q.mode == tsd_pkg::TSD_DLY_FIXED && fab_free
    |=> $stable(tap_value_out))
    else $error("fixed delay moved");

  init_hold_a: assert property ( // [R13] [R17]
    !ser_running ##1 !ser_running |-> ser_out == $past(ctrl_q.init_val))
    else $error("serial output left its initial value");

  byte_out_a: assert property ( // [R7] [R10]
    take && ctrl_q.wide8 |=> s_byte_out)
    else $error("byte not serialized low bit first");

  nibble_out_a: assert property ( // [R7] [R10]
    take && !ctrl_q.wide8 |=> s_nib_out)
    else $error("nibble not serialized low bit first");

  nibble_ready_a: assert property ( // [R10]
    take && !ctrl_q.wide8 |=> !par_ready [*3] ##1 par_ready)
    else $error("nibble pacing wrong");

  tri_direct_a: assert property ( // [R8] [R12]
    !ctrl_q.tsel_byte |-> t_out == direct_tristate_in)
    else $error("direct tristate not passed through");

  tri_byte_a: assert property ( // [R8] [R11]
    ctrl_q.tsel_byte |-> t_out == $past(byte_tristate_in))
    else $error("byte tristate not registered");

  early_flag_a: assert property ( // [R2]
    early_ev |=> early_q [*2])
    else $error("early load not flagged");

  jump_flag_a: assert property ( // [R3]
    jump_ev |=> jump_q)
    else $error("oversized tap jump not flagged");

  bus_echo_a: assert property ( // [R9]
    1'b1 |=> tx_ctrl_out[12:4] ==
      $past(tap_value_out))
    else $error("control bus tap stale");

endmodule
`default_nettype wire

// [tsd_defines.svh]
// Constants of the transmit serializer and delay slice
`ifndef TSD_DEFINES_SVH
`define TSD_DEFINES_SVH

// ==========================================================
// Register map, byte addresses
`define TSD_ADDR_CTRL 8'h00
`define TSD_ADDR_PROG 8'h04
`define TSD_ADDR_STAT 8'h08

// ==========================================================
// Reset values
`define TSD_CTRL_W 5
`define TSD_CTRL_RST 5'h07
`define TSD_TAP_RST 9'h000
`define TSD_INIT_RST 1'b1
`define TSD_READY_RST 1'b1

// ==========================================================
// Serializer and tap arithmetic
`define TSD_CNT8 3'h7
`define TSD_CNT4 3'h3
`define TSD_CNT_ONE 3'h1
`define TSD_DIV8 4'h4
`define TSD_DIV4 4'h2
`define TSD_TAP_STEP 9'h001
`define TSD_MAX_JUMP 9'h008
`define TSD_MIN_BACK 9'h1f8

`endif

// [tsd_pkg.sv]
// Types shared by the transmit serializer and delay slice
`default_nettype none
package tsd_pkg;

  // ==========================================================
  // Delay line modes
  typedef enum logic [1:0] {
    TSD_DLY_FIXED = 2'b00,
    TSD_DLY_VAR_LOAD = 2'b01,
    TSD_DLY_VARIABLE = 2'b10
  } tsd_dly_mode_t;

  // ==========================================================
  // Control register layout
  typedef struct packed {
    tsd_dly_mode_t mode;
    logic tsel_byte;
    logic init_val;
    logic wide8;
  } tsd_ctrl_t;

  // ==========================================================
  // Status register layout
  typedef struct packed {
    logic [18:0] zero;
    logic running;
    logic jump_err;
    logic early_err;
    logic div_mism;
    logic [8:0] tap;
  } tsd_status_t;

  // ==========================================================
  // Dedicated 40-bit buses to and from the nibble controller
  typedef struct packed {
    logic [23:0] rsvd;
    logic [3:0] div_mode;
    logic comp_valid;
    logic [8:0] comp_delta;
    logic [1:0] spare;
  } tsd_ctrl_in_t;

  typedef struct packed {
    logic [25:0] rsvd;
    logic vtc_en;
    logic [8:0] tap;
    logic t_bit;
    logic ser_bit;
    logic wide8;
    logic running;
  } tsd_ctrl_out_t;

endpackage
`default_nettype wire

// [tsd_delay_line.sv]
// Tap counter of the programmable output delay line
`timescale 1ns/100ps
`default_nettype none
`include "tsd_defines.svh"

module tsd_delay_line (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire tsd_pkg::tsd_dly_mode_t mode,
  input wire logic load,
  input wire logic ce,
  input wire logic inc,
  input wire logic [8:0] tap_in,
  input wire logic vtc_en,
  input wire logic comp_valid,
  input wire logic [8:0] comp_tap,
  input wire logic prog_wr,
  input wire logic [8:0] prog_tap,
  output logic [8:0] tap_q
);

  // ==========================================================
  // Tap register; programming wins, then compensation
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tap_q <= `TSD_TAP_RST;
    end else if (prog_wr) begin
      tap_q <= prog_tap; // [R4]
    end else if (vtc_en) begin
      if (comp_valid) begin
        tap_q <= comp_tap; // [R4] [R6]
      end
    end else if (mode == tsd_pkg::TSD_DLY_VAR_LOAD && load && !ce) begin
      tap_q <= tap_in; // [R1] [R14]
    end else if (mode != tsd_pkg::TSD_DLY_FIXED && ce) begin
      // Nine-bit arithmetic wraps 511 to 0 and back
      if (inc) begin
        tap_q <= tap_q + `TSD_TAP_STEP; // [R15] [R16]
      end else begin
        tap_q <= tap_q - `TSD_TAP_STEP; // [R15] [R16]
      end
    end
  end

endmodule
`default_nettype wire

// [tsd_serializer.sv]
// Parallel to serial converter of the transmit slice
`timescale 1ns/100ps
`default_nettype none
`include "tsd_defines.svh"

module tsd_serializer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wide8,
  input wire logic init_val,
  input wire logic [7:0] par_data,
  input wire logic par_valid,
  output logic par_ready,
  output logic ser_out,
  output logic running
);

  logic [2:0] cnt_q;
  logic [7:0] shreg_q;
  logic take;

  assign take = par_valid && par_ready;

  // ==========================================================
  // Shift register, low bit first
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 3'h0;
      shreg_q <= 8'h00;
    end else if (take) begin
      shreg_q <= {1'b0, par_data[7:1]};
      cnt_q <= wide8 ? `TSD_CNT8 : `TSD_CNT4; // [R10]
    end else if (cnt_q != 3'h0) begin
      shreg_q <= {1'b0, shreg_q[7:1]};
      cnt_q <= cnt_q - `TSD_CNT_ONE;
    end
  end

  // ==========================================================
  // Serial bit; holds the initial value until the first word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_out <= `TSD_INIT_RST; // [R13]
    end else if (take) begin
      ser_out <= par_data[0]; // [R7]
    end else if (cnt_q != 3'h0) begin
      ser_out <= shreg_q[0]; // [R7]
    end else if (!running) begin
      ser_out <= init_val; // [R13] [R17]
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      running <= 1'b0;
    end else if (take) begin
      running <= 1'b1; // [R17]
    end
  end

  // Ready only when the next cycle finds the shifter empty
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      par_ready <= `TSD_READY_RST;
    end else begin
      par_ready <= !take && (cnt_q <= `TSD_CNT_ONE);
    end
  end

endmodule
`default_nettype wire

// [tsd_fabric_src.sv]
// Fabric-side word source feeding the transmit slice
`timescale 1ns/100ps
`default_nettype none

module tsd_fabric_src (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic push,
  input wire logic [7:0] word,
  input wire logic [3:0] lag,
  input wire logic par_ready,
  output logic [7:0] par_data,
  output logic par_valid
);
  // ==========================================================
  // Word queue and offer
  logic [7:0] q[$];
  int wait_n;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q.delete();
      wait_n = 0;
      par_valid <= 1'b0;
      par_data <= 8'h00;
    end else begin
      if (par_valid && par_ready) begin
        void'(q.pop_front());
        wait_n = int'(lag);
      end
      if (push) begin
        q.push_back(word);
      end
      // Word held until taken; idle data toggles
      if (q.size() != 0 && wait_n == 0) begin
        par_valid <= 1'b1;
        par_data <= q[0];
      end else begin
        par_valid <= 1'b0;
        par_data <= ~par_data;
        if (wait_n != 0) begin
          wait_n--;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [test_tx_serializer_delay_slice.sv]
// Self-checking testbench of the transmit serializer and delay slice
`timescale 1ns/100ps
`default_nettype none
`include "tsd_defines.svh"

module test_tx_serializer_delay_slice;
  logic core_clk, arst_n, reg_wr, reg_rd, par_valid, par_ready;
  logic [7:0] reg_addr, par_data, word, cur;
  logic [31:0] reg_wdata, reg_rdata;
  logic [8:0] tap_value_in, tap_value_out;
  logic tap_load, tap_ce, tap_inc, vt_comp_enable, push, w8;
  logic direct_tristate_in, byte_tristate_in, ser_out, t_out;
  logic [39:0] rx_ctrl_in, rx_ctrl_out, tx_ctrl_out;
  logic [3:0] lag;
  tsd_pkg::tsd_ctrl_in_t ctl_in;
  int failures = 0;
  int samples_checked = 0;
  int bits_left = 0;
  int idx = 0;

  tsd_top u_tsd_top (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .par_data(par_data),
    .par_valid(par_valid), .par_ready(par_ready),
    .tap_value_in(tap_value_in), .tap_load(tap_load), .tap_ce(tap_ce),
    .tap_inc(tap_inc), .vt_comp_enable(vt_comp_enable),
    .tap_value_out(tap_value_out), .direct_tristate_in(direct_tristate_in),
    .byte_tristate_in(byte_tristate_in), .ser_out(ser_out), .t_out(t_out),
    .rx_ctrl_in(rx_ctrl_in), .rx_ctrl_out(rx_ctrl_out),
    .tx_ctrl_in(ctl_in), .tx_ctrl_out(tx_ctrl_out));

  tsd_fabric_src u_tsd_fabric_src (.core_clk(core_clk), .arst_n(arst_n),
    .push(push), .word(word), .lag(lag), .par_ready(par_ready),
    .par_data(par_data), .par_valid(par_valid));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [39:0] seen,
                     input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", 40'(reg_rdata & m), 40'(exp));
    @(posedge core_clk);
    #1;
    chk("reg_rdata idle", 40'(reg_rdata), 40'h0);
  endtask

  task automatic load(input logic [8:0] v);
    @(posedge core_clk);
    tap_value_in <= v;
    @(posedge core_clk);
    tap_load <= 1'b1;
    @(posedge core_clk);
    tap_load <= 1'b0;
    #1;
  endtask

  task automatic step(input logic up, input int n);
    @(posedge core_clk);
    tap_ce <= 1'b1;
    tap_inc <= up;
    repeat (n) @(posedge core_clk);
    tap_ce <= 1'b0;
    #1;
  endtask

  task automatic send(input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    push <= 1'b1;
    word <= a;
    @(posedge core_clk);
    word <= b;
    @(posedge core_clk);
    push <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge core_clk);
    while (bits_left != 0 || par_valid !== 1'b0) begin
      @(posedge core_clk);
      n++;
      if (n > 60) begin
        failures++;
        $display("CHECK FAILED serial idle expected 0 seen %0d", bits_left);
        stop_test();
      end
    end
    #1;
  endtask

  // ==========================================================
  // Serial stream monitor, bit0 first
  always @(posedge core_clk) begin
    if (bits_left > 0) begin
      chk("ser_out", 40'(ser_out), 40'(cur[idx]));
      chk("par_ready", 40'(par_ready), 40'(bits_left == 1));
      idx++;
      bits_left--;
    end
    if (arst_n && par_valid && par_ready) begin
      cur = par_data;
      idx = 0;
      bits_left = w8 ? 8 : 4;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tap_value_in = 9'h000;
    tap_load = 1'b0;
    tap_ce = 1'b0;
    tap_inc = 1'b0;
    vt_comp_enable = 1'b0;
    direct_tristate_in = 1'b1;
    byte_tristate_in = 1'b1;
    rx_ctrl_in = 40'ha5c3963c00;
    ctl_in = '0;
    ctl_in.div_mode = 4'h4;
    push = 1'b0;
    word = 8'h00;
    lag = 4'h0;
    w8 = 1'b1;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    chk("tap_value_out", 40'(tap_value_out), 40'h0);
    chk("ser_out", 40'(ser_out), 40'h1);
    chk("t_out", 40'(t_out), 40'h1);
    chk("rx_ctrl_out", rx_ctrl_out, 40'h0);
    chk("tx_ctrl_out", tx_ctrl_out, 40'h0);
    rd(`TSD_ADDR_CTRL, 32'h1f, 32'h07);
    rd(8'h0c, 32'hffffffff, 32'h0);
    wr(`TSD_ADDR_CTRL, 32'h05);
    repeat (2) @(posedge core_clk);
    #1;
    chk("ser_out", 40'(ser_out), 40'h0);
    wr(`TSD_ADDR_CTRL, 32'h0f);
    load(9'h005);
    chk("tap_value_out", 40'(tap_value_out), 40'h005);
    rd(`TSD_ADDR_STAT, 32'heff, 32'h005);
    step(1'b1, 3);
    chk("tap_value_out", 40'(tap_value_out), 40'h008);
    load(9'h001);
    chk("tap_value_out", 40'(tap_value_out), 40'h001);
    step(1'b0, 2);
    chk("tap_value_out", 40'(tap_value_out), 40'h1ff);
    step(1'b1, 1);
    chk("tap_value_out", 40'(tap_value_out), 40'h000);
    // Early load with a large jump: applied and flagged
    @(posedge core_clk);
    tap_value_in <= 9'h060;
    tap_load <= 1'b1;
    @(posedge core_clk);
    tap_load <= 1'b0;
    #1;
    chk("tap_value_out", 40'(tap_value_out), 40'h060);
    rd(`TSD_ADDR_STAT, 32'hc00, 32'hc00);
    wr(`TSD_ADDR_STAT, 32'hc00);
    rd(`TSD_ADDR_STAT, 32'hc00, 32'h0);
    // Compensation of the programmed tap
    @(posedge core_clk);
    vt_comp_enable <= 1'b1;
    ctl_in.comp_valid <= 1'b1;
    ctl_in.comp_delta <= 9'h003;
    wr(`TSD_ADDR_PROG, 32'h010);
    repeat (3) @(posedge core_clk);
    #1;
    chk("tap_value_out", 40'(tap_value_out), 40'h013);
    @(posedge core_clk);
    ctl_in.comp_valid <= 1'b0;
    load(9'h020);
    chk("tap_value_out", 40'(tap_value_out), 40'h013);
    chk("rx_ctrl_out", rx_ctrl_out, {rx_ctrl_in[39:9], 9'h010});
    chk("tx_ctrl_out", 40'(tx_ctrl_out[39:4]), 40'({26'h0, 1'b1, 9'h013}));
    @(posedge core_clk);
    vt_comp_enable <= 1'b0;
    ctl_in.comp_valid <= 1'b0;
    // Serial words, back to back then with a slow source
    send(8'hb4, 8'h3c);
    wait_idle();
    @(posedge core_clk);
    lag <= 4'h2;
    send(8'h81, 8'h7e);
    wait_idle();
    wr(`TSD_ADDR_CTRL, 32'h0e);
    w8 = 1'b0;
    rd(`TSD_ADDR_STAT, 32'h200, 32'h200);
    send(8'hfa, 8'h05);
    wait_idle();
    // Tristate sources
    @(posedge core_clk);
    byte_tristate_in <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("t_out", 40'(t_out), 40'h0);
    wr(`TSD_ADDR_CTRL, 32'h0b);
    @(posedge core_clk);
    direct_tristate_in <= 1'b0;
    #1;
    chk("t_out", 40'(t_out), 40'h0);
    @(posedge core_clk);
    direct_tristate_in <= 1'b1;
    #1;
    chk("t_out", 40'(t_out), 40'h1);
    // Variable mode steps but ignores load; fixed mode holds
    wr(`TSD_ADDR_CTRL, 32'h13);
    load(9'h015);
    chk("tap_value_out", 40'(tap_value_out), 40'h013);
    step(1'b1, 2);
    chk("tap_value_out", 40'(tap_value_out), 40'h015);
    wr(`TSD_ADDR_CTRL, 32'h03);
    step(1'b0, 1);
    chk("tap_value_out", 40'(tap_value_out), 40'h015);
    stop_test();
  end
endmodule

`default_nettype wire
